//--- design/tdm_pkg.sv
package tdm_pkg;

    // Widths of the status word, the sensor sample and the register path
    localparam int STATUS_W = 32;
    localparam int SAMPLE_W = 16;
    localparam int RADDR_W = 44;

    // Device register holding the latest sensor sample
    localparam logic [RADDR_W-1:0] TEMP_SAMPLE_ADDR = 44'h080c00000d8;

    // Status word layout
    localparam int ST_STARTED_BIT = 0;
    localparam int ST_DONE_BIT = 1;
    localparam int ST_ALARM0_BIT = 17;
    localparam int ST_ALARM1_BIT = 18;
    localparam logic [STATUS_W-1:0] STATUS_RESET = 32'h0000_0000;

    // Thresholds in raw sample units: first sample at or above 85 C, 100 C
    localparam logic [SAMPLE_W-1:0] ALARM0_SAMPLE = 16'h08c5;
    localparam logic [SAMPLE_W-1:0] ALARM1_SAMPLE = 16'h099e;

    // Startup wait, in ticks of the 100 MHz link rate
    localparam int STARTUP_TICKS = 8;

    // Rates: pclk and the documented block rate, as an enable divider
    localparam int PCLK_MHZ = 200;
    localparam int LINK_MHZ = 100;
    localparam int TICK_DIV = PCLK_MHZ / LINK_MHZ;

    // Sample to tenths of a degree: -701 + 2830 * sample / 4096
    localparam int TEMP_OFFSET_DC = -701;
    localparam int TEMP_GAIN_DC = 2830;
    localparam int TEMP_SHIFT = 12;

    // Controller register map over APB
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] SAMPLE_OFS = 8'h08;
    localparam logic [7:0] TEMP_OFS = 8'h0c;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_CAPTURE_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;

    // Ticks between two sample reads by the controller
    localparam int POLL_TICKS = 16;

    // JTAG pins in, JTAG pin out, and the shared pass-through bus
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst_n;
    } tdm_jtag_in_t;

    typedef struct packed {
        logic tdo;
    } tdm_jtag_out_t;

    typedef tdm_jtag_in_t tdm_jtap_bus_t;

    // Startup sequence of the device
    typedef enum logic [1:0] {
        TDM_IDLE = 2'b00,
        TDM_WAIT = 2'b01,
        TDM_RUN = 2'b10
    } tdm_state_t;

endpackage : tdm_pkg

//--- design/tdm_link_if.sv
`timescale 1ns/1ps
interface tdm_link_if
    import tdm_pkg::*;
();
    logic tick; // 100 MHz enable from the user end
    logic start; // Launch of the startup sequence
    logic [STATUS_W-1:0] status; // Device status word
    tdm_jtap_bus_t jtap_bus; // JTAG forwarded by the device
    logic tdo_bus; // Test data returned toward the device
    logic reg_rd; // One-cycle register read request
    logic [RADDR_W-1:0] reg_addr; // Register address
    logic reg_rvalid; // One-cycle read answer
    logic [STATUS_W-1:0] reg_rdata; // Read data, sample in low bits
    logic reg_err; // Unmapped address, with reg_rvalid

    // Documented device end
    modport dev (
        input tick, start, tdo_bus, reg_rd, reg_addr,
        output status, jtap_bus, reg_rvalid, reg_rdata, reg_err
    );

    // User logic and capture-unit end
    modport usr (
        output tick, start, tdo_bus, reg_rd, reg_addr,
        input status, jtap_bus, reg_rvalid, reg_rdata, reg_err
    );
endinterface : tdm_link_if

//--- design/tdm_device.sv
// Behaviour
// - Sensor set to continuous sampling at startup
// - Status bit 17 high at 85 C
// - Status bit 18 high at 100 C
// - Only report alarms, never shut down
// - Latest 16-bit sample in readable register
// - Sample to degrees: 71.4+283(s/4096-0.5)
// - After a short wait status becomes 0x3
// - Startup begins once start is high
// - Block timed by a 100 MHz clock; here a 100 MHz enable on the 200 MHz pclk
// - Unused returned test data held at zero
// - JTAG forwarded on bus, test data returned
// - Only the unit-style capture block attaches
// - 32-bit status: progress, errors and alarms; no error sources here, error bits stay 0
`timescale 1ns/1ps
module tdm_device
    import tdm_pkg::*;
#(
    parameter int STARTUP_WAIT = STARTUP_TICKS // Ticks before completion
)
(
    input wire logic pclk,
    input wire logic presetn,
    tdm_link_if.dev lnk,
    input tdm_jtag_in_t jtag_in,
    output tdm_jtag_out_t jtag_out,
    output logic sens_continuous,
    input wire logic [SAMPLE_W-1:0] sens_sample,
    input wire logic sens_valid
);

    localparam int WAIT_W = $clog2(STARTUP_WAIT + 1);
    localparam logic [WAIT_W-1:0] WAIT_LAST = WAIT_W'(STARTUP_WAIT - 1);
    localparam logic [WAIT_W-1:0] WAIT_ZERO = '0;

    tdm_state_t state_reg; // Startup sequence state
    tdm_state_t state_next; // Its next value
    logic [WAIT_W-1:0] wait_reg; // Ticks spent waiting
    logic continuous_reg; // Sensor programmed to run freely
    logic [SAMPLE_W-1:0] sample_reg; // Latest sensor reading
    logic alarm0_reg; // At or above the first limit
    logic alarm1_reg; // At or above the second limit
    logic [STATUS_W-1:0] status_reg; // Status word as driven
    logic [STATUS_W-1:0] status_next; // Its next value
    logic rvalid_reg; // Read answer strobe
    logic [STATUS_W-1:0] rdata_reg; // Read answer data
    logic rerr_reg; // Read answer error flag
    logic sample_take; // A new reading is accepted

    // Startup sequencing; IDLE and WAIT advance only on the 100 MHz enable
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            TDM_IDLE:
            begin
                // Nothing happens until start is seen high
                if (lnk.tick && lnk.start)
                begin
                    state_next = TDM_WAIT;
                end
            end
            TDM_WAIT:
            begin
                // Short fixed wait, then the sequence is complete
                if (lnk.tick && wait_reg == WAIT_LAST)
                begin
                    state_next = TDM_RUN;
                end
            end
            TDM_RUN:
            begin
                // Final state; only reset leaves it
                state_next = TDM_RUN;
            end
            default:
            begin
                // Illegal code falls back to the start
                state_next = TDM_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= TDM_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Wait counter, counts ticks only while waiting
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wait_reg <= WAIT_ZERO;
        end
        else if (state_reg != TDM_WAIT)
        begin
            // Cleared outside the wait so a restart is clean
            wait_reg <= WAIT_ZERO;
        end
        else if (lnk.tick)
        begin
            wait_reg <= wait_reg + 1'b1;
        end
    end

    // Sensor mode: set once on completion, never dropped afterwards
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            continuous_reg <= 1'b0;
        end
        else if (state_next == TDM_RUN)
        begin
            continuous_reg <= 1'b1;
        end
    end

    assign sens_continuous = continuous_reg;

    // Readings count only once the sensor has been programmed
    assign sample_take = sens_valid && continuous_reg;

    // Latest reading, kept for the register read path
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sample_reg <= '0;
        end
        else if (sample_take)
        begin
            sample_reg <= sens_sample;
        end
    end

    // Alarms compare each new reading against both raw thresholds;
    // comparing raw samples avoids a divider in this path
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            alarm0_reg <= 1'b0;
            alarm1_reg <= 1'b0;
        end
        else if (sample_take)
        begin
            // Both rise and fall with every reading
            alarm0_reg <= (sens_sample >= ALARM0_SAMPLE);
            alarm1_reg <= (sens_sample >= ALARM1_SAMPLE);
        end
    end

    // Status word assembly; no error sources exist, so those bits stay 0.
    // Alarms only report: no output here can stop the chip.
    always_comb
    begin
        status_next = STATUS_RESET;
        status_next[ST_STARTED_BIT] = (state_reg != TDM_IDLE);
        status_next[ST_DONE_BIT] = (state_reg == TDM_RUN);
        status_next[ST_ALARM0_BIT] = alarm0_reg;
        status_next[ST_ALARM1_BIT] = alarm1_reg;
    end

    // Status held in flops so the user side sees clean levels
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_reg <= STATUS_RESET;
        end
        else
        begin
            status_reg <= status_next;
        end
    end

    assign lnk.status = status_reg;

    // Register read port: answer exactly one cycle after the request
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rerr_reg <= 1'b0;
        end
        else
        begin
            rvalid_reg <= lnk.reg_rd;
            if (lnk.reg_rd)
            begin
                if (lnk.reg_addr == TEMP_SAMPLE_ADDR)
                begin
                    // Sample in the low bits, upper bits zero
                    rdata_reg <= STATUS_W'(sample_reg);
                    rerr_reg <= 1'b0;
                end
                else
                begin
                    // Unmapped address reads zero with an error
                    rdata_reg <= '0;
                    rerr_reg <= 1'b1;
                end
            end
        end
    end

    assign lnk.reg_rvalid = rvalid_reg;
    assign lnk.reg_rdata = rdata_reg;
    assign lnk.reg_err = rerr_reg;

    // JTAG pass-through; kept as wires because the JTAG pins have their
    // own timing and a flop on pclk would skew tdo against tck
    assign lnk.jtap_bus = jtag_in;
    assign jtag_out.tdo = lnk.tdo_bus;

endmodule : tdm_device

//--- design/tdm_user.sv
`timescale 1ns/1ps
module tdm_user
    import tdm_pkg::*;
#(
    parameter int POLL_WAIT = POLL_TICKS // Ticks between sample reads
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output tdm_jtap_bus_t cap_jtap,
    input wire logic cap_tdo,
    tdm_link_if.usr lnk
);

    localparam int DIV_W = $clog2(TICK_DIV + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);
    localparam int POLL_W = $clog2(POLL_WAIT + 1);
    localparam logic [POLL_W-1:0] POLL_LAST = POLL_W'(POLL_WAIT - 1);

    logic [DIV_W-1:0] div_reg; // Divider toward the 100 MHz enable
    logic [1:0] ctrl_reg; // Start and capture-present bits
    logic [POLL_W-1:0] poll_reg; // Ticks since the last read
    logic pend_reg; // Read in flight toward the device
    logic rd_reg; // Read request strobe
    logic [SAMPLE_W-1:0] sample_reg; // Latest sample fetched
    logic signed [31:0] temp_reg; // Tenths of a degree
    logic [31:0] prdata_reg; // Read data captured at setup
    logic hit; // Address is mapped
    logic signed [31:0] prod; // Scaled sample

    // Divider: one-cycle enable at the documented block rate
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_reg <= '0;
        end
        else if (div_reg == DIV_LAST)
        begin
            div_reg <= '0;
        end
        else
        begin
            div_reg <= div_reg + 1'b1;
        end
    end

    assign lnk.tick = (div_reg == DIV_LAST);

    // Control register, written in the access phase only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg <= CTRL_RESET;
        end
        else if (psel && penable && pwrite && paddr == CTRL_OFS)
        begin
            ctrl_reg <= pwdata[1:0];
        end
    end

    assign lnk.start = ctrl_reg[CTRL_START_BIT];

    // Capture unit hookup; with none present tdo is held at zero
    assign lnk.tdo_bus = ctrl_reg[CTRL_CAPTURE_BIT] ? cap_tdo : 1'b0;
    assign cap_jtap = lnk.jtap_bus;

    // Periodic sample read, one outstanding at a time
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            poll_reg <= '0;
            pend_reg <= 1'b0;
            rd_reg <= 1'b0;
        end
        else
        begin
            rd_reg <= 1'b0;
            if (lnk.reg_rvalid)
            begin
                pend_reg <= 1'b0;
            end
            else if (!pend_reg && lnk.tick)
            begin
                if (poll_reg == POLL_LAST)
                begin
                    poll_reg <= '0;
                    pend_reg <= 1'b1;
                    rd_reg <= 1'b1;
                end
                else
                begin
                    poll_reg <= poll_reg + 1'b1;
                end
            end
        end
    end

    assign lnk.reg_rd = rd_reg;
    assign lnk.reg_addr = TEMP_SAMPLE_ADDR;

    // Fixed-point conversion; tenths keep the 71.4 offset exact.
    // Scaled straight from the answer so sample and temp move together.
    assign prod = 32'(TEMP_GAIN_DC)
        * $signed({16'h0000, lnk.reg_rdata[SAMPLE_W-1:0]});

    // Sample and converted temperature, updated on each good answer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sample_reg <= '0;
            temp_reg <= '0;
        end
        else if (lnk.reg_rvalid && !lnk.reg_err)
        begin
            sample_reg <= lnk.reg_rdata[SAMPLE_W-1:0];
            temp_reg <= 32'(TEMP_OFFSET_DC) + (prod >>> TEMP_SHIFT);
        end
    end

    // APB decode; read data captured in the setup cycle
    assign hit = (paddr == CTRL_OFS) || (paddr == STATUS_OFS)
        || (paddr == SAMPLE_OFS) || (paddr == TEMP_OFS);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_reg <= '0;
        end
        else if (psel && !penable)
        begin
            case (paddr)
                CTRL_OFS: prdata_reg <= {30'h0, ctrl_reg};
                STATUS_OFS: prdata_reg <= lnk.status;
                SAMPLE_OFS: prdata_reg <= {16'h0000, sample_reg};
                TEMP_OFS: prdata_reg <= temp_reg;
                default: prdata_reg <= '0;
            endcase
        end
    end

    // Zero-wait answer in the first access cycle
    assign pready = psel && penable;
    assign pslverr = psel && penable && !hit;
    assign prdata = prdata_reg;

endmodule : tdm_user

//--- tb/tdm_link_properties.sv
`timescale 1ns/1ps
module tdm_link_properties
    import tdm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick,
    input wire logic start,
    input wire logic [STATUS_W-1:0] status,
    input wire logic reg_rd,
    input wire logic [RADDR_W-1:0] reg_addr,
    input wire logic reg_rvalid,
    input wire logic [STATUS_W-1:0] reg_rdata,
    input wire logic reg_err
);
    // One domain, one reset
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // A good answer from the sample register
    sequence s_read_ok;
        reg_rvalid && !reg_err;
    endsequence

    // Request on the fixed address, answer one cycle on
    sequence s_request;
        reg_rd && reg_addr == TEMP_SAMPLE_ADDR;
    endsequence

    property p_alarm0;
        s_read_ok |-> ##1
            status[ST_ALARM0_BIT] == (reg_rdata[15:0] >= ALARM0_SAMPLE);
    endproperty
    a_alarm0: assert property (p_alarm0)
        else $error("alarm 0 disagrees with sample");

    property p_alarm1;
        s_read_ok |-> ##1
            status[ST_ALARM1_BIT] == (reg_rdata[15:0] >= ALARM1_SAMPLE);
    endproperty
    a_alarm1: assert property (p_alarm1)
        else $error("alarm 1 disagrees with sample");

    property p_answer;
        reg_rd |-> s_request ##1 s_read_ok ##0 reg_rdata[31:16] == 16'h0;
    endproperty
    a_answer: assert property (p_answer)
        else $error("sample read answered wrongly");

    property p_no_stray;
        reg_rvalid |-> $past(reg_rd);
    endproperty
    a_no_stray: assert property (p_no_stray)
        else $error("answer without request");

    property p_unused;
        status[31:19] == 13'h0 && status[16:2] == 15'h0;
    endproperty
    a_unused: assert property (p_unused)
        else $error("status has stray bits");

    property p_hold;
        status[ST_DONE_BIT] |=> status[1:0] == 2'h3;
    endproperty
    a_hold: assert property (p_hold)
        else $error("startup completion lost");

    property p_start;
        $rose(status[ST_STARTED_BIT]) |-> $past(start, 2);
    endproperty
    a_start: assert property (p_start)
        else $error("startup without start");

    // Completion no sooner than four cycles after startup began
    property p_wait;
        $rose(status[ST_DONE_BIT]) |-> $past(status[ST_STARTED_BIT], 4);
    endproperty
    a_wait: assert property (p_wait)
        else $error("startup wait skipped");

    property p_tick;
        tick |=> !tick ##1 tick;
    endproperty
    a_tick: assert property (p_tick)
        else $error("link tick not every second cycle");
endmodule : tdm_link_properties

//--- tb/tb.sv
`timescale 1ns/1ps
module tb
    import tdm_pkg::*;
;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    tdm_jtap_bus_t cap_jtap;
    logic cap_tdo;
    tdm_jtag_in_t jtag_in;
    tdm_jtag_out_t jtag_out;
    logic sens_continuous;
    logic [SAMPLE_W-1:0] sens_sample;
    logic sens_valid;
    int n_fail = 0;
    int n_tests = 0;
    int cycles = 0;
    int t;
    logic [31:0] q;
    logic e;
    // Samples at and beside both thresholds, then back to cold
    logic [15:0] smp [5] = '{16'h08c4, 16'h08c5, 16'h099d, 16'h099e, 16'h0};
    logic [1:0] alm [5] = '{2'h0, 2'h1, 2'h1, 2'h3, 2'h0};

    tdm_link_if lnk ();
    tdm_device #(.STARTUP_WAIT(4)) tdm_device_inst (.pclk, .presetn,
        .lnk(lnk.dev), .jtag_in, .jtag_out, .sens_continuous,
        .sens_sample, .sens_valid);
    tdm_user #(.POLL_WAIT(16)) tdm_user_inst (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .cap_jtap, .cap_tdo, .lnk(lnk.usr));
    tdm_link_properties tdm_link_properties_inst (.pclk, .presetn,
        .tick(lnk.tick), .start(lnk.start), .status(lnk.status),
        .reg_rd(lnk.reg_rd), .reg_addr(lnk.reg_addr),
        .reg_rvalid(lnk.reg_rvalid), .reg_rdata(lnk.reg_rdata),
        .reg_err(lnk.reg_err));

    // 200 MHz
    initial pclk = 1'b0;
    always #2.5 pclk = ~pclk;

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run

    // Ceiling well above the several hundred cycles the tests need
    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_fail++;
            $display("MISMATCH run exp done got hung");
            complete_run();
        end
    end

    task automatic chk(input string nm, input logic [31:0] x,
        input logic [31:0] g);
        n_tests++;
        if (g !== x)
        begin
            n_fail++;
            $display("MISMATCH %s exp %h got %h", nm, x, g);
        end
    endtask : chk

    // One APB transfer; entered just after an edge, leaves three edges later
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic er);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No local limit; only the run ceiling bounds this wait
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        chk("pready", 32'h1, {31'h0, pready});
        r = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, q, e);
    endtask : wr

    task automatic rchk(input string nm, input logic [7:0] a,
        input logic [31:0] x);
        apb(1'b0, a, 32'h0, q, e);
        chk(nm, x, q);
        chk("slverr", 32'h0, {31'h0, e});
    endtask : rchk

    // Wait for a poll answer, then realign on the next edge
    task automatic wait_rv();
        int n;
        n = 0;
        do
        begin
            @(posedge pclk);
            #1;
            n++;
        end
        while (lnk.reg_rvalid !== 1'b1 && n < 200);
        chk("poll", 32'h1, {31'h0, lnk.reg_rvalid});
        @(posedge pclk);
    endtask : wait_rv

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        cap_tdo = 1'b0;
        jtag_in = 4'h0;
        sens_sample = 16'h0;
        sens_valid = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk("ctrl", CTRL_OFS, 32'h0);
        rchk("status", STATUS_OFS, 32'h0);
        chk("cont", 32'h0, {31'h0, sens_continuous});
        // A hot reading before startup must be ignored
        sens_sample <= ALARM1_SAMPLE;
        sens_valid <= 1'b1;
        @(posedge pclk);
        sens_valid <= 1'b0;
        repeat (40) @(posedge pclk);
        rchk("idle", STATUS_OFS, 32'h0);
        apb(1'b0, 8'h10, 32'h0, q, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, q);
        $display("test reset done");
        wr(CTRL_OFS, 32'h1);
        for (int i = 0; i < 100 && sens_continuous !== 1'b1; i++)
            @(posedge pclk);
        chk("cont", 32'h1, {31'h0, sens_continuous});
        repeat (4) @(posedge pclk);
        rchk("done", STATUS_OFS, 32'h3);
        wr(CTRL_OFS, 32'h0);
        repeat (20) @(posedge pclk);
        rchk("kept", STATUS_OFS, 32'h3);
        wr(STATUS_OFS, 32'hffffffff);
        rchk("status ro", STATUS_OFS, 32'h3);
        $display("test startup done");
        foreach (smp[i])
        begin
            wait_rv();
            sens_sample <= smp[i];
            sens_valid <= 1'b1;
            @(posedge pclk);
            sens_valid <= 1'b0;
            sens_sample <= ~smp[i];
            wait_rv();
            wait_rv();
            t = {13'h0, alm[i], 17'h3};
            rchk("alarms", STATUS_OFS, t);
            rchk("sample", SAMPLE_OFS, {16'h0, smp[i]});
            t = TEMP_OFFSET_DC + ((TEMP_GAIN_DC * int'(smp[i])) >>> 12);
            rchk("temp", TEMP_OFS, t);
            chk("cont", 32'h1, {31'h0, sens_continuous});
        end
        $display("test alarms done");
        // Capture absent, then present
        for (int m = 0; m < 2; m++)
        begin
            wr(CTRL_OFS, {30'h0, m[0], 1'b1});
            for (int i = 0; i < 16; i++)
            begin
                @(posedge pclk);
                jtag_in <= i[3:0];
                cap_tdo <= i[0];
                #1;
                chk("jtap", i, {28'h0, cap_jtap});
                chk("tdo", m & i, {31'h0, jtag_out});
            end
        end
        $display("test jtag done");
        complete_run();
    end
endmodule : tb
